// ### hw/prom_program_verify_port.sv
// Purpose: write/verify port of the on-chip program store
// Assumes: all pin inputs are asynchronous to clk and synchronised here
// Notes:   data nibble ports are open drain; out is always low
`timescale 1ns/10ps
`include "prom_port_cfg.svh"

module prom_program_verify_port
#(
	parameter int DEPTH  = `PROM_DEPTH,
	parameter int ADDR_W = `PROM_ADDR_W,
	parameter int DATA_W = `PROM_DATA_W
)
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        ce,
	input  wire logic        vpp_high,
	input  wire logic        vdd_prog,
	input  wire logic [3:0]  prog_mode_select,
	input  wire logic        addr_step_clock,
	input  wire logic        addr_step_clock_inverted,
	input  wire logic [3:0]  data_low_nibble_in,
	output logic      [3:0]  data_low_nibble_out,
	output logic      [3:0]  data_low_nibble_oe,
	input  wire logic [3:0]  data_high_nibble_in,
	output logic      [3:0]  data_high_nibble_out,
	output logic      [3:0]  data_high_nibble_oe,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr
);

	// ***********************************************
	// mode decode
	// ***********************************************
	function automatic prom_port_pkg::prog_mode_t decode_mode
	(
		input logic       powered,
		input logic [3:0] sel
	);
		prom_port_pkg::prog_mode_t m;
		m = prom_port_pkg::mode_none;
		if (!powered)
			m = prom_port_pkg::mode_none;
		else if (sel == `MODE_CODE_CLEAR)
			m = prom_port_pkg::mode_clear;
		else if (sel == `MODE_CODE_WRITE)
			m = prom_port_pkg::mode_write;
		else if (sel == `MODE_CODE_VERIFY)
			m = prom_port_pkg::mode_verify;
		else if ((sel & `MODE_MASK_INHIBIT) == `MODE_CODE_INHIBIT)
			m = prom_port_pkg::mode_inhibit;
		return m;
	endfunction

	function automatic logic [2:0] mode_code
	(
		input prom_port_pkg::prog_mode_t m
	);
		return 3'(m);
	endfunction

	// ***********************************************
	// pin synchronisers
	// ***********************************************
	logic [3:0]        sel_s;
	logic [1:0]        supply_s;
	logic [1:0]        step_s;
	logic [7:0]        data_s;

	pin_sync #(.WIDTH(4)) sync_sel
	(
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.pin   (prog_mode_select),
		.level (sel_s)
	);

	pin_sync #(.WIDTH(2)) sync_supply
	(
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.pin   ({vdd_prog, vpp_high}),
		.level (supply_s)
	);

	pin_sync #(.WIDTH(2)) sync_step
	(
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.pin   ({addr_step_clock_inverted, addr_step_clock}),
		.level (step_s)
	);

	pin_sync #(.WIDTH(8)) sync_data
	(
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.pin   ({data_high_nibble_in, data_low_nibble_in}),
		.level (data_s)
	);

	// ***********************************************
	// operation select
	// ***********************************************
	logic                      powered;
	prom_port_pkg::prog_mode_t mode;
	logic                      program_enable;

	assign powered = supply_s[0] & supply_s[1];
	assign mode    = decode_mode(powered, sel_s);

	// ***********************************************
	// address stepping
	// ***********************************************
	logic              step_prev;
	logic              step_rise;
	logic              clock_skew;
	logic [1:0]        step_count;
	logic [ADDR_W-1:0] address;
	logic [7:0]        write_pulses;
	logic              in_write_prev;

	// the inverted clock only qualifies the edge; a skewed pair is shown in status
	assign step_rise  = step_s[0] & ~step_prev & step_s[1] == 1'b0;
	assign clock_skew = step_s[0] == step_s[1];

	always_ff @(posedge clk)
	begin
		if (reset)
			step_prev <= 1'b0;
		else if (ce)
			step_prev <= step_s[0];
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			step_count <= 2'h0;
			address    <= '0;
		end
		else if (ce)
		begin
			unique case (mode)
				prom_port_pkg::mode_clear:
				begin
					step_count <= 2'h0;
					address    <= '0;
				end
				prom_port_pkg::mode_none:
				begin
					step_count <= step_count;
				end
				prom_port_pkg::mode_write,
				prom_port_pkg::mode_verify,
				prom_port_pkg::mode_inhibit:
				begin
					if (step_rise)
					begin
						step_count <= step_count + 2'h1;
						if (step_count == 2'(`STEPS_PER_ADDR - 1))
						begin
							// wraps past the last byte rather than running off the store
							if (address == ADDR_W'(DEPTH - 1))
								address <= '0;
							else
								address <= address + ADDR_W'(1);
						end
					end
				end
			endcase
		end
	end

	// counts write mode entries on the current byte, for software to watch
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			in_write_prev <= 1'b0;
			write_pulses  <= 8'h00;
		end
		else if (ce)
		begin
			in_write_prev <= mode == prom_port_pkg::mode_write;
			if (mode == prom_port_pkg::mode_clear
				|| (mode != prom_port_pkg::mode_none && step_rise && step_count == 2'h3))
				write_pulses <= 8'h00;
			else if (mode == prom_port_pkg::mode_write && !in_write_prev)
			begin
				if (write_pulses != 8'hff)
					write_pulses <= write_pulses + 8'h01;
			end
		end
	end

	// ***********************************************
	// store and data lines
	// ***********************************************
	logic              store_wr;
	logic [DATA_W-1:0] store_rd;
	logic [DATA_W-1:0] drive_byte;
	logic              drive_en;

	// held write mode rewrites the same byte every cycle while program_enable is set; last level wins
	assign store_wr = mode == prom_port_pkg::mode_write && program_enable;

	prom_store #(.DEPTH(DEPTH), .ADDR_W(ADDR_W), .DATA_W(DATA_W)) store
	(
		.clk     (clk),
		.ce      (ce),
		.wr_en   (store_wr),
		.wr_addr (address),
		.wr_data (data_s),
		.rd_addr (address),
		.rd_data (store_rd)
	);

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			drive_byte <= '0;
			drive_en   <= 1'b0;
		end
		else if (ce)
		begin
			drive_byte <= store_rd;
			drive_en   <= mode == prom_port_pkg::mode_verify;
		end
	end

	// open drain: pull low where the byte has a zero, release elsewhere
	assign data_low_nibble_out  = 4'h0;
	assign data_high_nibble_out = 4'h0;
	assign data_low_nibble_oe   = drive_en ? ~drive_byte[3:0] : 4'h0;
	assign data_high_nibble_oe  = drive_en ? ~drive_byte[7:4] : 4'h0;

	// ***********************************************
	// register bus slave
	// ***********************************************
	logic setup;
	logic access;
	logic mapped;

	assign setup   = psel & ~penable;
	assign access  = psel & penable & ce;
	assign pready  = ce;
	assign mapped  = paddr == `REG_CTRL || paddr == `REG_STATUS || paddr == `REG_PULSES;
	assign pslverr = access & ~mapped;

	always_ff @(posedge clk)
	begin
		if (reset)
			program_enable <= `CTRL_RESET;
		else if (access && pwrite && paddr == `REG_CTRL)
			program_enable <= pwdata[0];
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			prdata <= 32'h0000_0000;
		else if (ce && setup)
		begin
			prdata <= 32'h0000_0000;
			if (paddr == `REG_CTRL)
				prdata[0] <= program_enable;
			else if (paddr == `REG_STATUS)
			begin
				prdata[ADDR_W-1:0]                         <= address;
				prdata[`STATUS_MODE_LSB +: 3]              <= mode_code(mode);
				prdata[`STATUS_ACTIVE_BIT]                 <= powered;
				prdata[`STATUS_SKEW_BIT]                   <= clock_skew;
			end
			else if (paddr == `REG_PULSES)
				prdata[7:0] <= write_pulses;
		end
	end

endmodule

// ### common/prom_port_cfg.svh
// Purpose: constants of the program store write/verify port
// Assumes: included by its bare name
// Notes:   offsets are byte addresses on the register bus
`ifndef PROM_PORT_CFG_SVH
`define PROM_PORT_CFG_SVH

// ***********************************************
// store geometry
// ***********************************************
`define PROM_DEPTH         8064
`define PROM_ADDR_W        13
`define PROM_DATA_W        8
`define PROM_LAST_ADDR     13'h1f7f
`define STEPS_PER_ADDR     4

// ***********************************************
// mode select codes, bit 0 in the lsb
// ***********************************************
`define MODE_CODE_CLEAR    4'h5
`define MODE_CODE_WRITE    4'he
`define MODE_CODE_VERIFY   4'hc
`define MODE_MASK_INHIBIT  4'hd
`define MODE_CODE_INHIBIT  4'hd

// ***********************************************
// register map
// ***********************************************
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define REG_PULSES         8'h08
`define CTRL_RESET         1'h1
`define STATUS_MODE_LSB    16
`define STATUS_ACTIVE_BIT  20
`define STATUS_SKEW_BIT    21

`endif

// ### common/prom_port_pkg.sv
// Purpose: shared types of the program store write/verify port
// Assumes: nothing
// Notes:   constants live in prom_port_cfg.svh
package prom_port_pkg;

	// ***********************************************
	// operation picked by the mode select pins
	// ***********************************************
	typedef enum logic [2:0]
	{
		mode_none,
		mode_clear,
		mode_write,
		mode_verify,
		mode_inhibit
	} prog_mode_t;

endpackage

// ### hw/pin_sync.sv
// Purpose: two flip-flop synchroniser for a group of pin levels
// Assumes: levels only; a pulse narrower than one cycle may be lost
// Notes:   first stage is read by the second stage only
`timescale 1ns/10ps

module pin_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level
);

	logic [WIDTH-1:0] stage_one;

	// ***********************************************
	// two stages
	// ***********************************************
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			stage_one <= '0;
			level     <= '0;
		end
		else if (ce)
		begin
			stage_one <= pin;
			level     <= stage_one;
		end
	end

endmodule

// ### hw/prom_store.sv
// Purpose: byte-wide program store with one write and one read port
// Assumes: addresses beyond DEPTH are never written
// Notes:   read data come out of a register, one cycle after the address
`timescale 1ns/10ps

module prom_store
#(
	parameter int DEPTH  = 8064,
	parameter int ADDR_W = 13,
	parameter int DATA_W = 8
)
(
	input  wire logic              clk,
	input  wire logic              ce,
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic [ADDR_W-1:0] rd_addr,
	output logic      [DATA_W-1:0] rd_data
);

	logic [DATA_W-1:0] cells [DEPTH];

	// ***********************************************
	// write and registered read
	// ***********************************************
	always_ff @(posedge clk)
	begin
		if (ce && wr_en)
			cells[wr_addr] <= wr_data;
	end

	always_ff @(posedge clk)
	begin
		if (ce)
			rd_data <= cells[rd_addr];
	end

endmodule

// ### verification/prom_port_asserts.sv
// Purpose: port checks of the write/verify block
// Assumes: ce dropped by the bench only while the bus is idle
// Notes:   pins reach the logic after two sync stages
`timescale 1ns/10ps

module prom_port_asserts
(
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        ce,
	input wire logic        vpp_high,
	input wire logic        vdd_prog,
	input wire logic [3:0]  prog_mode_select,
	input wire logic [3:0]  data_low_nibble_out,
	input wire logic [3:0]  data_low_nibble_oe,
	input wire logic [3:0]  data_high_nibble_out,
	input wire logic [3:0]  data_high_nibble_oe,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr
);
	// ****
	// checks
	// ****
	logic [7:0] oe;
	logic       pwr;
	assign oe = {data_high_nibble_oe, data_low_nibble_oe};
	assign pwr = vpp_high && vdd_prog;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence st_rd;
		psel && !penable && paddr == 8'h04;
	endsequence
	out_low_a:
		assert property ((data_low_nibble_out | data_high_nibble_out) == 4'h0)
		else $error("nibble output not low");
	oe_verify_a:
		assert property (oe != 8'h00 |-> $past(prog_mode_select, 3) == 4'hc)
		else $error("lines driven outside verify");
	unpowered_quiet_a:
		assert property ((!vpp_high)[*5] |-> oe == 8'h00)
		else $error("lines driven while unpowered");
	ready_follows_a:
		assert property (pready == ce)
		else $error("pready differs from ce");
	unmapped_err_a:
		assert property (psel && penable |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
		else $error("pslverr wrong");
	clear_zero_a:
		assert property ((pwr && prog_mode_select == 4'h5)[*5] ##0 st_rd |=> prdata[12:0] == 0)
		else $error("clear left address nonzero");
	mode_field_a:
		assert property ((pwr && prog_mode_select == 4'hc)[*5] ##0 st_rd |=> prdata[20:16] == 5'h13)
		else $error("verify mode not reported");
	power_field_a:
		assert property ((!vdd_prog)[*5] ##0 st_rd |=> prdata[20:16] == 5'h00)
		else $error("mode seen without supply");
	cover property (oe != 8'h00);
	cover property (pwr && prog_mode_select == 4'he);
	cover property (psel && penable && pslverr);
endmodule

bind prom_program_verify_port prom_port_asserts prom_port_asserts_inst
(
	.clk(clk), .reset(reset), .ce(ce), .vpp_high(vpp_high), .vdd_prog(vdd_prog),
	.prog_mode_select(prog_mode_select), .data_low_nibble_out(data_low_nibble_out),
	.data_low_nibble_oe(data_low_nibble_oe), .data_high_nibble_out(data_high_nibble_out),
	.data_high_nibble_oe(data_high_nibble_oe), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr)
);

// ### verification/prom_programmer_model.sv
// Purpose: programmer model driving mode, step and data pins
// Assumes: 1 ms write unit scaled to PULSE cycles
// Notes:   data lines are resolved in the bench
`timescale 1ns/10ps
`include "prom_port_cfg.svh"

module prom_programmer_model
#(
	parameter int PULSE = 12
)
(
	input  wire logic       clk,
	input  wire logic [7:0] data_wire,
	output logic            vpp_high,
	output logic            vdd_prog,
	output logic [3:0]      mode,
	output logic            step,
	output logic            step_n,
	output logic            drive,
	output logic [7:0]      drive_data
);
	// ****
	// pin sequences
	// ****
	initial
	begin
		vpp_high = 0;
		vdd_prog = 0;
		mode = 0;
		step = 0;
		step_n = 1;
		drive = 0;
		drive_data = 0;
	end
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask
	// pins need two sync stages, so eight cycles is ample
	task automatic set_mode(input logic [3:0] m);
		@(posedge clk);
		mode <= m;
		wait_n(8);
	endtask
	task automatic power(input logic on);
		if (on)
			wait_n(1000);
		set_mode(`MODE_CODE_CLEAR);
		@(posedge clk);
		vpp_high <= on;
		vdd_prog <= on;
		wait_n(8);
		set_mode(on ? `MODE_CODE_INHIBIT : `MODE_CODE_CLEAR);
	endtask
	task automatic step_addr();
		repeat (4)
		begin
			@(posedge clk);
			step <= 1;
			step_n <= 0;
			wait_n(4);
			step <= 0;
			step_n <= 1;
			wait_n(3);
		end
		wait_n(5);
	endtask
	task automatic read_byte(output logic [7:0] v);
		set_mode(`MODE_CODE_VERIFY);
		v = data_wire;
	endtask
	task automatic write_pulse(input logic [7:0] v, input int len);
		@(posedge clk);
		drive <= 1;
		drive_data <= v;
		set_mode(`MODE_CODE_WRITE);
		wait_n(len);
		set_mode(`MODE_CODE_INHIBIT);
		drive <= 0;
	endtask
	task automatic program_byte(input logic [7:0] v, output int n);
		logic [7:0] got;
		n = 0;
		got = ~v;
		while (got !== v && n < 3)
		begin
			n++;
			write_pulse(v, PULSE);
			read_byte(got);
		end
		if (got === v)
			write_pulse(v, n * PULSE);
	endtask
endmodule

// ### verification/prom_program_verify_port_tb.sv
// Purpose: bench of the write/verify port
// Assumes: ce dropped only while the bus is idle; zero wait APB slave
// Notes:   open-drain data lines pulled up here
`timescale 1ns/10ps
`include "prom_port_cfg.svh"

module prom_program_verify_port_tb;
	logic        clk = 0;
	logic        reset = 1;
	logic        ce = 1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0;
	logic        pready, pslverr, vpp_high, vdd_prog, step, step_n, drive, e;
	logic [31:0] prdata, r;
	logic [3:0]  mode, lo_oe, hi_oe;
	logic [7:0]  drive_data, data_wire, b;
	int          err_total = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          n;
	logic [7:0]  pat [3] = '{8'h5a, 8'hc3, 8'h0f};

	// ****
	// clock, wires, instances
	// ****
	always #5 clk = ~clk;
	assign data_wire = (drive ? drive_data : 8'hff) & ~{hi_oe, lo_oe};
	prom_program_verify_port prom_program_verify_port_inst
	(
		.clk(clk), .reset(reset), .ce(ce), .vpp_high(vpp_high), .vdd_prog(vdd_prog),
		.prog_mode_select(mode), .addr_step_clock(step), .addr_step_clock_inverted(step_n),
		.data_low_nibble_in(data_wire[3:0]), .data_low_nibble_out(), .data_low_nibble_oe(lo_oe),
		.data_high_nibble_in(data_wire[7:4]), .data_high_nibble_out(),
		.data_high_nibble_oe(hi_oe), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr)
	);
	prom_programmer_model pm
	(
		.clk(clk), .data_wire(data_wire), .vpp_high(vpp_high), .vdd_prog(vdd_prog),
		.mode(mode), .step(step), .step_n(step_n), .drive(drive), .drive_data(drive_data)
	);

	// ****
	// tasks
	// ****
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic conclude();
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// whole run needs some 1650 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			conclude();
		end
	end

	// ****
	// sequence
	// ****
	initial
	begin
		repeat (5) @(posedge clk);
		reset <= 0;
		// pins reach the logic two cycles after release; skew bit is stale before
		repeat (3) @(posedge clk);
		apb(0, `REG_STATUS, 0);
		chk("status", 0, r);
		apb(0, `REG_CTRL, 0);
		chk("enable", 1, r);
		apb(1, 8'h0c, 32'hffff_ffff);
		chk("slverr", 1, e);
		pm.power(1);
		apb(0, `REG_STATUS, 0);
		chk("inhibit", 32'h0014_0000, r);
		chk("idle lines", 8'hff, data_wire);
		// step pulses while frozen must not move the address
		ce <= 0;
		pm.step_addr();
		ce <= 1;
		apb(0, `REG_STATUS, 0);
		chk("frozen", 32'h0014_0000, r);
		for (int i = 0; i < 3; i++)
		begin
			pm.program_byte(pat[i], n);
			chk("tries", 1, n);
			apb(0, `REG_PULSES, 0);
			chk("pulses", 2, r[7:0]);
			pm.step_addr();
		end
		apb(0, `REG_STATUS, 0);
		chk("address", 32'h0014_0003, r);
		pm.set_mode(`MODE_CODE_CLEAR);
		apb(0, `REG_STATUS, 0);
		chk("cleared", 32'h0011_0000, r);
		// blocked write at address 0; the dump below must still show the first byte
		apb(1, `REG_CTRL, 0);
		apb(0, `REG_CTRL, 0);
		chk("enable", 0, r);
		pm.set_mode(`MODE_CODE_INHIBIT);
		pm.write_pulse(8'h00, 12);
		apb(1, `REG_CTRL, 1);
		for (int i = 0; i < 3; i++)
		begin
			pm.read_byte(b);
			chk("dump", pat[i], b);
			pm.step_addr();
		end
		apb(0, `REG_STATUS, 0);
		chk("verify", 32'h0013_0003, r);
		pm.power(0);
		apb(0, `REG_STATUS, 0);
		chk("unpowered", 0, r);
		conclude();
	end
endmodule
